//--- hdl/cprf_map.svh
// constants for the program register file
`ifndef CPRF_MAP_SVH
`define CPRF_MAP_SVH
`define CPRF_ZERO_IDX      5'h00
`define CPRF_EBP_IDX       5'h1e
`define CPRF_PC_MASK       32'h03fffffe
`define CPRF_PC_RESET      32'h00000000
`define CPRF_PC_STEP       32'h00000004
`define CPRF_SR_PC_MASK    32'h03ffffff
`define CPRF_SR_INT_PC     5'h00
`define CPRF_SR_INT_FLAGS  5'h01
`define CPRF_SR_NMI_PC     5'h02
`define CPRF_SR_NMI_FLAGS  5'h03
`define CPRF_SR_INT_SRC    5'h04
`define CPRF_SR_STATUS     5'h05
`define CPRF_SR_CALL_PC    5'h10
`define CPRF_SR_CALL_FLAGS 5'h11
`define CPRF_SR_TRAP_PC    5'h12
`define CPRF_SR_TRAP_FLAGS 5'h13
`define CPRF_SR_CALL_BASE  5'h14
`define CPRF_STATUS_MASK   32'h000000ff
`endif

//--- hdl/cprf_pkg.sv
// types for the program register file
package cprf_pkg;
    typedef logic [31:0] cprf_word_t;
    typedef logic [4:0]  cprf_idx_t;
    typedef enum logic [1:0] {
        CPRF_SR_PLAIN,
        CPRF_SR_PC,
        CPRF_SR_FLAGS,
        CPRF_SR_NONE
    } cprf_sr_kind_t;
endpackage : cprf_pkg

//--- hdl/cprf_pc.sv
// program counter with 26-bit even address
`timescale 1ns/1ps
`default_nettype none
`include "cprf_map.svh"
module cprf_pc (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // update
    input  wire logic              inc,
    input  wire logic              load,
    input  wire cprf_pkg::cprf_word_t target,
    // state
    output var  cprf_pkg::cprf_word_t pc
);
    cprf_pkg::cprf_word_t next_pc;
    cprf_pkg::cprf_word_t sum;

    always_comb begin
        sum = pc + `CPRF_PC_STEP;
        next_pc = pc;
        if (load) begin
            next_pc = target & `CPRF_PC_MASK; // RULE_07 RULE_09
        end else if (inc) begin
            next_pc = sum & `CPRF_PC_MASK; // RULE_08
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc <= `CPRF_PC_RESET;
        end else begin
            pc <= next_pc; // RULE_06
        end
    end

    chk_pc_even: assert property (@(posedge clk) disable iff (rst) // RULE_09
        pc[0] == 1'b0) else $error("pc odd");
    chk_pc_upper_zero: assert property (@(posedge clk) disable iff (rst) // RULE_07
        pc[31:26] == 6'h00) else $error("pc upper bits set");
    chk_pc_wrap: assert property (@(posedge clk) disable iff (rst) // RULE_08
        (inc && !load && pc[25:1] == 25'h1fffffe) |=> pc == 32'h00000000)
        else $error("pc did not wrap");
endmodule : cprf_pc
`default_nettype wire

//--- hdl/cprf_top.sv
// program and system register file of the core
`timescale 1ns/1ps
`default_nettype none
`include "cprf_map.svh"
// Overview of operation
// RULE_01: thirty-two general registers, index 0 to 31, hold data or addresses.
// RULE_02: all program and system registers are 32 bits wide.
// RULE_03: index 0 always reads as zero.
// RULE_04: writes to index 0 are discarded.
// RULE_05: short load and store use register 30 as memory base.
// RULE_06: program counter holds the executing instruction address.
// RULE_07: program counter bits 31 to 26 always read zero.
// RULE_08: carry out of bit 25 is dropped, address wraps in 26 bits.
// RULE_09: program counter bit 0 is held at zero.
// RULE_10: system registers read by store-system, written by load-system, by number.
// RULE_11: interrupt source register ignores system register loads.
// RULE_12: status word bits 31 to 8 always read zero.
module cprf_top (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // general register read ports
    input  wire cprf_pkg::cprf_idx_t  rd_a_idx,
    input  wire cprf_pkg::cprf_idx_t  rd_b_idx,
    output var  cprf_pkg::cprf_word_t rd_a_data,
    output var  cprf_pkg::cprf_word_t rd_b_data,
    // general register write port
    input  wire logic                 wr_en,
    input  wire cprf_pkg::cprf_idx_t  wr_idx,
    input  wire cprf_pkg::cprf_word_t wr_data,
    // short load/store base
    output var  cprf_pkg::cprf_word_t short_base,
    // program counter
    input  wire logic                 pc_inc,
    input  wire logic                 pc_load,
    input  wire cprf_pkg::cprf_word_t pc_target,
    output var  cprf_pkg::cprf_word_t pc,
    // system register access
    input  wire logic                 sys_load_en,
    input  wire logic                 sys_store_en,
    input  wire cprf_pkg::cprf_idx_t  sys_idx,
    input  wire cprf_pkg::cprf_word_t sys_load_data,
    output var  cprf_pkg::cprf_word_t sys_store_data,
    // hardware source of the interrupt code
    input  wire logic                 int_src_set,
    input  wire cprf_pkg::cprf_word_t int_src_code
);
    // ---------------------------------------------------------------
    // general registers
    // ---------------------------------------------------------------
    cprf_pkg::cprf_word_t gpr      [31:0]; // RULE_01 RULE_02
    cprf_pkg::cprf_word_t next_gpr [31:0];
    cprf_pkg::cprf_word_t next_rd_a;
    cprf_pkg::cprf_word_t next_rd_b;
    cprf_pkg::cprf_word_t next_short_base;

    // reading a just-written register returns the new value, saving a bypass upstream
    function automatic cprf_pkg::cprf_word_t read_gpr(input cprf_pkg::cprf_idx_t idx,
                                                      input cprf_pkg::cprf_word_t cur);
        if (idx == `CPRF_ZERO_IDX) begin
            read_gpr = 32'h00000000; // RULE_03
        end else if (wr_en && wr_idx == idx) begin
            read_gpr = wr_data;
        end else begin
            read_gpr = cur;
        end
    endfunction : read_gpr

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            next_gpr[i] = gpr[i];
        end
        if (wr_en && wr_idx != `CPRF_ZERO_IDX) begin
            next_gpr[wr_idx] = wr_data; // RULE_04
        end
        next_gpr[0]     = 32'h00000000; // RULE_03
        next_rd_a       = read_gpr(rd_a_idx, gpr[rd_a_idx]);
        next_rd_b       = read_gpr(rd_b_idx, gpr[rd_b_idx]);
        next_short_base = read_gpr(`CPRF_EBP_IDX, gpr[`CPRF_EBP_IDX]); // RULE_05
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= 32'h00000000;
            end
            rd_a_data  <= 32'h00000000;
            rd_b_data  <= 32'h00000000;
            short_base <= 32'h00000000;
        end else begin
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= next_gpr[i];
            end
            rd_a_data  <= next_rd_a;
            rd_b_data  <= next_rd_b;
            short_base <= next_short_base;
        end
    end

    // ---------------------------------------------------------------
    // program counter
    // ---------------------------------------------------------------
    cprf_pc u_pc (
        .clk    (clk),
        .rst    (rst),
        .inc    (pc_inc),
        .load   (pc_load),
        .target (pc_target),
        .pc     (pc)
    );

    // ---------------------------------------------------------------
    // system registers
    // ---------------------------------------------------------------
    cprf_pkg::cprf_word_t sr      [31:0];
    cprf_pkg::cprf_word_t next_sr [31:0];
    cprf_pkg::cprf_word_t next_store;

    // pc save slots keep the low 26 bits, bit 0 included; reserved numbers hold nothing
    function automatic cprf_pkg::cprf_sr_kind_t sr_kind(input cprf_pkg::cprf_idx_t idx);
        unique case (idx)
            `CPRF_SR_INT_PC, `CPRF_SR_NMI_PC, `CPRF_SR_CALL_PC, `CPRF_SR_TRAP_PC: begin
                sr_kind = cprf_pkg::CPRF_SR_PC;
            end
            `CPRF_SR_INT_FLAGS, `CPRF_SR_NMI_FLAGS, `CPRF_SR_STATUS,
            `CPRF_SR_CALL_FLAGS, `CPRF_SR_TRAP_FLAGS: begin
                sr_kind = cprf_pkg::CPRF_SR_FLAGS;
            end
            `CPRF_SR_CALL_BASE: begin
                sr_kind = cprf_pkg::CPRF_SR_PLAIN;
            end
            default: begin
                sr_kind = cprf_pkg::CPRF_SR_NONE;
            end
        endcase
    endfunction : sr_kind

    function automatic cprf_pkg::cprf_word_t sr_shape(input cprf_pkg::cprf_idx_t idx,
                                                      input cprf_pkg::cprf_word_t v);
        unique case (sr_kind(idx))
            cprf_pkg::CPRF_SR_PC:    sr_shape = v & `CPRF_SR_PC_MASK;
            cprf_pkg::CPRF_SR_FLAGS: sr_shape = v & `CPRF_STATUS_MASK; // RULE_12
            cprf_pkg::CPRF_SR_PLAIN: sr_shape = v;
            cprf_pkg::CPRF_SR_NONE:  sr_shape = 32'h00000000;
        endcase
    endfunction : sr_shape

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            next_sr[i] = sr[i];
        end
        if (sys_load_en && sys_idx != `CPRF_SR_INT_SRC) begin
            next_sr[sys_idx] = sr_shape(sys_idx, sys_load_data); // RULE_10 RULE_11
        end
        if (int_src_set) begin
            next_sr[`CPRF_SR_INT_SRC] = int_src_code;
        end
        next_store = sys_store_en ? sr[sys_idx] : sys_store_data; // RULE_10
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                sr[i] <= 32'h00000000;
            end
            sys_store_data <= 32'h00000000;
        end else begin
            for (int i = 0; i < 32; i++) begin
                sr[i] <= next_sr[i];
            end
            sys_store_data <= next_store;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // load steps that the system register checks start from
    sequence s_status_load;
        sys_load_en && sys_idx == `CPRF_SR_STATUS;
    endsequence
    sequence s_slot_load;
        sys_load_en && sr_kind(sys_idx) == cprf_pkg::CPRF_SR_PC;
    endsequence
    sequence s_reserved_load;
        sys_load_en && sys_idx != `CPRF_SR_INT_SRC && sr_kind(sys_idx) == cprf_pkg::CPRF_SR_NONE;
    endsequence

    chk_zero_reads: assert property (@(posedge clk) disable iff (rst) // RULE_03
        (rd_a_idx == 5'h00) |=> rd_a_data == 32'h00000000) else $error("r zero nonzero");
    chk_zero_reads_b: assert property (@(posedge clk) disable iff (rst) // RULE_03
        (rd_b_idx == 5'h00) |=> rd_b_data == 32'h00000000) else $error("second port zero nonzero");
    chk_zero_write: assert property (@(posedge clk) disable iff (rst) // RULE_04
        (wr_en && wr_idx == 5'h00) |=> gpr[0] == 32'h00000000) else $error("zero written");
    chk_gpr_write: assert property (@(posedge clk) disable iff (rst) // RULE_01
        (wr_en && wr_idx != 5'h00) |=> gpr[$past(wr_idx)] == $past(wr_data))
        else $error("write lost");
    chk_read_a: assert property (@(posedge clk) disable iff (rst) // RULE_01
        (rd_a_idx != 5'h00 && !(wr_en && wr_idx == rd_a_idx)) |=> rd_a_data == $past(gpr[rd_a_idx]))
        else $error("read wrong");
    chk_read_bypass: assert property (@(posedge clk) disable iff (rst) // RULE_01
        (wr_en && wr_idx == rd_a_idx && rd_a_idx != 5'h00) |=> rd_a_data == $past(wr_data))
        else $error("bypass wrong");
    chk_base_ptr: assert property (@(posedge clk) disable iff (rst) // RULE_05
        (wr_en && wr_idx == `CPRF_EBP_IDX) |=> short_base == $past(wr_data)) else $error("base wrong");
    chk_base_hold: assert property (@(posedge clk) disable iff (rst) // RULE_05
        !(wr_en && wr_idx == `CPRF_EBP_IDX) |=> short_base == gpr[`CPRF_EBP_IDX]) else $error("base stale");
    chk_int_src_ro: assert property (@(posedge clk) disable iff (rst) // RULE_11
        (!int_src_set) |=> $stable(sr[`CPRF_SR_INT_SRC])) else $error("interrupt source changed");
    chk_status_rsvd: assert property (@(posedge clk) disable iff (rst) // RULE_12
        sr[`CPRF_SR_STATUS][31:8] == 24'h000000) else $error("status reserved set");
    chk_status_load: assert property (@(posedge clk) disable iff (rst) // RULE_12
        s_status_load |=> sr[`CPRF_SR_STATUS] == ($past(sys_load_data) & `CPRF_STATUS_MASK))
        else $error("status load wrong");
    chk_slot_shape: assert property (@(posedge clk) disable iff (rst) // RULE_10
        s_slot_load |=> sr[$past(sys_idx)][31:26] == 6'h00) else $error("save slot upper bits set");
    chk_reserved_empty: assert property (@(posedge clk) disable iff (rst) // RULE_10
        s_reserved_load |=> sr[$past(sys_idx)] == 32'h00000000) else $error("reserved number holds data");
    chk_sr_store: assert property (@(posedge clk) disable iff (rst) // RULE_10
        sys_store_en |=> sys_store_data == $past(sr[sys_idx])) else $error("store wrong");
    chk_store_hold: assert property (@(posedge clk) disable iff (rst) // RULE_10
        !sys_store_en |=> $stable(sys_store_data)) else $error("store moved");
endmodule : cprf_top
`default_nettype wire

//--- bench/cprf_pipe_model.sv
// pipeline stand-in that steps the program counter while running
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// fetch sequencer
// ----------------------------------------
module cprf_pipe_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control from the bench
    input  wire logic run,
    // towards the register file
    output var  logic pc_inc
);
    // registered like an issue stage, so each pc step lands two rising edges after the bench asks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_inc <= 1'b0;
        end else begin
            pc_inc <= run;
        end
    end
endmodule : cprf_pipe_model
`default_nettype wire

//--- bench/test_cprf_top.sv
// self-checking bench for the program register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module test_cprf_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 run = 1'b0;
    logic                 pc_inc;
    logic                 wr_en = 1'b0, pc_load = 1'b0, sys_load_en = 1'b0, sys_store_en = 1'b0, int_src_set = 1'b0;
    cprf_pkg::cprf_idx_t  rd_a_idx = 5'h00, rd_b_idx = 5'h00, wr_idx = 5'h00, sys_idx = 5'h00;
    cprf_pkg::cprf_word_t wr_data = 32'h0, pc_target = 32'h0, sys_load_data = 32'h0, int_src_code = 32'h0;
    cprf_pkg::cprf_word_t rd_a_data, rd_b_data, short_base, pc, sys_store_data;
    int                   n_fail = 0, comparisons = 0, cyc = 0;
    cprf_top uut (.clk(clk), .rst(rst), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data),
        .rd_b_data(rd_b_data), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .short_base(short_base),
        .pc_inc(pc_inc), .pc_load(pc_load), .pc_target(pc_target), .pc(pc), .sys_load_en(sys_load_en),
        .sys_store_en(sys_store_en), .sys_idx(sys_idx), .sys_load_data(sys_load_data),
        .sys_store_data(sys_store_data), .int_src_set(int_src_set), .int_src_code(int_src_code));
    cprf_pipe_model pipe (.clk(clk), .rst(rst), .run(run), .pc_inc(pc_inc));
    initial begin
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // a hang is cut short well above the roughly 140 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end
    // ----------------------------------------
    // shared steps, all entered at a falling edge
    // ----------------------------------------
    task step;
        @(negedge clk);
    endtask : step
    task wr(input cprf_pkg::cprf_idx_t i, input cprf_pkg::cprf_word_t d);
        wr_en = 1'b1; wr_idx = i; wr_data = d; step();
        wr_en = 1'b0; step();
    endtask : wr
    task rd(input cprf_pkg::cprf_idx_t a, input cprf_pkg::cprf_idx_t b);
        rd_a_idx = a;
        rd_b_idx = b;
        step();
    endtask : rd
    // expected contents: index 0 reads zero, every other index its own pattern
    function automatic cprf_pkg::cprf_word_t pat(input cprf_pkg::cprf_idx_t i);
        pat = (i == 5'h00) ? 32'h00000000 : ({8'(i), 24'ha5c300} ^ 32'h80000001);
    endfunction : pat
    task sys_ld(input cprf_pkg::cprf_idx_t i, input cprf_pkg::cprf_word_t d);
        sys_load_en = 1'b1; sys_idx = i; sys_load_data = d; step();
        sys_load_en = 1'b0; step();
    endtask : sys_ld
    task sys_st(input cprf_pkg::cprf_idx_t i);
        sys_store_en = 1'b1; sys_idx = i; step();
        sys_store_en = 1'b0; step();
    endtask : sys_st
    task pc_set(input cprf_pkg::cprf_word_t t);
        pc_load = 1'b1; pc_target = t; step();
        pc_load = 1'b0; step();
    endtask : pc_set
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_gpr;
        for (int i = 1; i < 32; i++) begin
            wr(5'(i), pat(5'(i)));
        end
        // the second port reads a different index so a swapped port shows up
        for (int i = 1; i < 32; i++) begin
            rd(5'(i), ~5'(i));
            `CHK("gpr_a", pat(5'(i)), rd_a_data)
            `CHK("gpr_b", pat(~5'(i)), rd_b_data)
        end
        rd(5'h00, 5'h00);
        wr(5'h00, 32'hffffffff);
        `CHK("zero_register", 32'h0, rd_a_data)
        `CHK("zero_register_b", 32'h0, rd_b_data)
        wr_en = 1'b1;
        wr_idx = 5'h05;
        wr_data = 32'h5a5a0005;
        rd_a_idx = 5'h05;
        step();
        wr_en = 1'b0;
        `CHK("gpr_bypass", 32'h5a5a0005, rd_a_data)
        step();
    endtask : t_gpr
    task t_base;
        wr(5'h1e, 32'h12345678);
        `CHK("element_base_pointer", 32'h12345678, short_base)
    endtask : t_base
    task t_pc;
        pc_set(32'h00001234);
        `CHK("pc_load", 32'h00001234, pc)
        run = 1'b1;
        step();
        run = 1'b0;
        step();
        `CHK("pc_step", 32'h00001238, pc)
        pc_set(32'hffffffff);
        `CHK("pc_mask", 32'h03fffffe, pc)
        `CHK("pc_bit0", 1'b0, pc[0])
        pc_set(32'h03fffffc);
        run = 1'b1; step(); run = 1'b0; step();
        `CHK("pc_wrap", 32'h0, pc)
    endtask : t_pc
    task t_sys;
        sys_ld(5'h14, 32'hdeadbeef);
        sys_st(5'h14);
        `CHK("sys_plain", 32'hdeadbeef, sys_store_data)
        int_src_set = 1'b1; int_src_code = 32'h00000090; step();
        int_src_set = 1'b0; step();
        sys_ld(5'h04, 32'h0000ffff);
        sys_st(5'h04);
        `CHK("interrupt_source_register", 32'h00000090, sys_store_data)
        sys_ld(5'h05, 32'hffffffff);
        sys_st(5'h05);
        `CHK("program_status_word", 32'h000000ff, sys_store_data)
        sys_ld(5'h00, 32'hffffffff);
        sys_st(5'h00);
        `CHK("sys_pc_slot", 32'h03ffffff, sys_store_data)
        sys_ld(5'h06, 32'hffffffff);
        sys_st(5'h06);
        `CHK("sys_reserved", 32'h0, sys_store_data)
    endtask : t_sys
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        `CHK("pc_reset", 32'h0, pc)
        t_gpr();
        t_base();
        t_pc();
        t_sys();
        test_done();
    end
endmodule : test_cprf_top
`default_nettype wire
